/* tilc_top.sv */
/*
 * trigger input and logger control: conditions the external trigger,
 * runs the logging start/stop sequence, drives the trigger output and
 * the status lamps, and exposes control and status over apb.
 * assumes channel traffic and frame strobes come from logic on pclk.
 */
// Decided for this implementation: the register addresses and the APB slave port.
// Notes on behaviour
// - software selects rising or falling trigger edge
// - falling mode fires when input is grounded
// - rising mode fires when input released high
// - input must hold about 30 ms to count
// - logging starts at reset or on trigger
// - optional configurable pulse on trigger output
// - armed lamp 90/10, logging lamp flashes fast
// - logger mode channel lamps follow traffic
// - interface mode power steady, channel flashes
// - config mode runs light across all lamps
// - trigger stop goes off bus, slow blink
`timescale 1ns/10ps
`default_nettype none

module tilc_top
#(
    parameter int unsigned DEB_CYC  = tilc_pkg::DEB_CYCLES,  // filter hold
    parameter int unsigned TICK_CYC = tilc_pkg::TICK_CYCLES  // lamp tick
)
(
    input  wire logic        pclk,          // system clock
    input  wire logic        presetn,       // async reset, active low
    input  wire logic [7:0]  paddr,         // apb byte address
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb access phase
    input  wire logic        pwrite,        // apb direction
    input  wire logic [31:0] pwdata,        // apb write data
    output logic [31:0]      prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // apb error, unmapped
    input  wire logic        trig_in,       // external trigger pin
    input  wire logic [1:0]  chan_traffic,  // per-channel traffic level
    input  wire logic [1:0]  chan_frame,    // per-channel frame strobe
    output logic             trig_out_o,    // trigger output, pull-down
    output logic             trig_out_oe,   // trigger output enable
    output logic             power_status_lamp,        // power lamp
    output logic             first_channel_port_lamp,  // channel 1 lamp
    output logic             second_channel_port_lamp, // channel 2 lamp
    output logic             err_lamp,      // error lamp
    output logic             info_lamp,     // info lamp
    output logic             logging_active,// logging in progress
    output logic             off_bus,       // stopped by trigger
    output logic             irq            // level interrupt
);

    // *****************************************************************
    // state
    // *****************************************************************
    typedef struct packed
    {
        tilc_pkg::tilc_state_e st;        // logger state
        logic [5:0]            ctrl;      // control register
        logic [2:0]            irq_st;    // sticky events
        logic [2:0]            irq_mask;  // interrupt enables
        logic [7:0]            pulse_len; // output pulse, ticks
        logic [7:0]            pulse_cnt; // output pulse remaining
        logic [31:0]           tick_cnt;  // tick divider
        logic [7:0]            phase;     // 1 s lamp phase
        logic [3:0]            run_cnt;   // running light step timer
        logic [2:0]            run_idx;   // running light position
        logic [1:0][3:0]       flash;     // per-channel flash timers
        logic [4:0]            lamps;     // registered lamp outputs
        logic [31:0]           rdata;     // read data, set in setup
        logic                  bad_addr;  // unmapped, set in setup
    } tilc_top_s;

    tilc_top_s r_reg;               // registered state
    tilc_top_s r_next;              // next state

    logic       deb_level;          // filtered trigger level
    logic       deb_rise;           // filtered rising edge
    logic       deb_fall;           // filtered falling edge
    logic       trig_evt;           // selected trigger edge
    logic       tick;               // 10 ms enable pulse
    logic       wr_acc;             // apb write access edge
    logic [1:0] chan_lamp;          // per-channel lamp level

    // *****************************************************************
    // trigger conditioning
    // *****************************************************************
    tilc_debounce
    #(
        .DEB_CYC (DEB_CYC)
    )
    u_deb
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_async (trig_in),
        .level     (deb_level),
        .rise      (deb_rise),
        .fall      (deb_fall)
    );

    // edge select: falling means pin grounded, rising means released
    assign trig_evt = r_reg.ctrl[tilc_pkg::CTRL_RISING] ? deb_rise
                                                        : deb_fall;

    assign tick   = (r_reg.tick_cnt == 32'(TICK_CYC - 1));
    assign wr_acc = psel & penable & pwrite;

    // *****************************************************************
    // per-channel lamp source
    // *****************************************************************
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_chan
            // interface mode flashes per frame, logger mode shows traffic
            assign chan_lamp[i] = r_reg.ctrl[tilc_pkg::CTRL_IFACE]
                                ? (r_reg.flash[i] != 4'h0)
                                : chan_traffic[i];
        end
    endgenerate

    // *****************************************************************
    // next state
    // *****************************************************************
    always_comb
    begin
        logic [2:0] irq_set;        // events raised this cycle
        irq_set = 3'h0;
        r_next  = r_reg;

        // timebase for every lamp and pulse timer
        r_next.tick_cnt = tick ? 32'h0000_0000
                               : r_reg.tick_cnt + 32'h0000_0001;
        if (tick)
        begin
            r_next.phase = (r_reg.phase == tilc_pkg::PHASE_LAST)
                         ? 8'h00 : r_reg.phase + 8'h01;
        end

        irq_set[tilc_pkg::IRQ_TRIG] = trig_evt;

        // logger sequence
        unique case (r_reg.st)
            tilc_pkg::ST_START:
            begin
                // configuration decides: log now or wait for trigger
                if (r_reg.ctrl[tilc_pkg::CTRL_START_TRIG])
                begin
                    r_next.st = tilc_pkg::ST_ARMED;
                end
                else
                begin
                    r_next.st = tilc_pkg::ST_LOG;
                    irq_set[tilc_pkg::IRQ_START] = 1'b1;
                end
            end
            tilc_pkg::ST_ARMED:
            begin
                if (trig_evt)
                begin
                    r_next.st = tilc_pkg::ST_LOG;
                    irq_set[tilc_pkg::IRQ_START] = 1'b1;
                end
            end
            tilc_pkg::ST_LOG:
            begin
                if (trig_evt && r_reg.ctrl[tilc_pkg::CTRL_STOP_TRIG])
                begin
                    r_next.st = tilc_pkg::ST_STOP;
                    irq_set[tilc_pkg::IRQ_STOP] = 1'b1;
                end
            end
            tilc_pkg::ST_STOP:
            begin
                // stays off bus until software re-arms
            end
            default:
                r_next.st = tilc_pkg::ST_START;
        endcase

        // trigger output pulse, length counted in ticks
        if (trig_evt && r_reg.ctrl[tilc_pkg::CTRL_OUT_EN])
        begin
            r_next.pulse_cnt = r_reg.pulse_len;
        end
        else if (tick && (r_reg.pulse_cnt != 8'h00))
        begin
            r_next.pulse_cnt = r_reg.pulse_cnt - 8'h01;
        end

        // per-channel flash stretchers, reloaded by each frame
        for (int i = 0; i < 2; i++)
        begin
            if (chan_frame[i])
            begin
                r_next.flash[i] = tilc_pkg::FLASH_TICKS;
            end
            else if (tick && (r_reg.flash[i] != 4'h0))
            begin
                r_next.flash[i] = r_reg.flash[i] - 4'h1;
            end
        end

        // running light stepper
        if (tick)
        begin
            if (r_reg.run_cnt == tilc_pkg::RUN_STEP_TICKS - 4'h1)
            begin
                r_next.run_cnt = 4'h0;
                r_next.run_idx = (r_reg.run_idx == 3'(tilc_pkg::NUM_LAMPS - 1))
                               ? 3'h0 : r_reg.run_idx + 3'h1;
            end
            else
            begin
                r_next.run_cnt = r_reg.run_cnt + 4'h1;
            end
        end

        // lamp outputs; config mode overrides everything
        if (r_reg.ctrl[tilc_pkg::CTRL_CONFIG])
        begin
            r_next.lamps = 5'(5'h01 << r_reg.run_idx);
        end
        else
        begin
            r_next.lamps = {2'b00, chan_lamp, 1'b0};
            if (r_reg.ctrl[tilc_pkg::CTRL_IFACE])
            begin
                r_next.lamps[0] = 1'b1;
            end
            else
            begin
                unique case (r_reg.st)
                    tilc_pkg::ST_ARMED:
                        r_next.lamps[0] = r_reg.phase < tilc_pkg::ARMED_ON_END;
                    tilc_pkg::ST_LOG:
                        r_next.lamps[0] = r_reg.phase[2];
                    tilc_pkg::ST_STOP:
                        r_next.lamps[0] = r_reg.phase < tilc_pkg::SLOW_ON_END;
                    default:
                        r_next.lamps[0] = 1'b0;
                endcase
            end
        end

        // apb setup: latch read data so prdata comes from a flop
        if (psel && !penable)
        begin
            r_next.bad_addr = 1'b0;
            r_next.rdata    = 32'h0000_0000;
            unique case (paddr)
                tilc_pkg::CTRL_OFS:
                    r_next.rdata = {26'h0, r_reg.ctrl};
                tilc_pkg::STATUS_OFS:
                    r_next.rdata = {25'h0, off_bus, trig_out_oe,
                                    deb_level, r_reg.st};
                tilc_pkg::IRQ_STAT_OFS:
                    r_next.rdata = {29'h0, r_reg.irq_st};
                tilc_pkg::IRQ_MASK_OFS:
                    r_next.rdata = {29'h0, r_reg.irq_mask};
                tilc_pkg::PULSE_LEN_OFS:
                    r_next.rdata = {24'h0, r_reg.pulse_len};
                default:
                    r_next.bad_addr = 1'b1;
            endcase
        end

        // apb write at the access edge; status clears by writing ones
        if (wr_acc)
        begin
            unique case (paddr)
                tilc_pkg::CTRL_OFS:
                begin
                    r_next.ctrl = pwdata[5:0];
                    if (pwdata[tilc_pkg::CTRL_RESTART])
                    begin
                        r_next.st = tilc_pkg::ST_START;
                    end
                end
                tilc_pkg::IRQ_STAT_OFS:
                    r_next.irq_st = r_reg.irq_st & ~pwdata[2:0];
                tilc_pkg::IRQ_MASK_OFS:
                    r_next.irq_mask = pwdata[2:0];
                tilc_pkg::PULSE_LEN_OFS:
                    r_next.pulse_len = pwdata[7:0];
                default:
                    r_next.irq_mask = r_reg.irq_mask;
            endcase
        end
        // a new event in the clearing cycle is kept
        r_next.irq_st = r_next.irq_st | irq_set;
    end

    // *****************************************************************
    // registers
    // *****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_reg <= '{st:        tilc_pkg::ST_START,
                       ctrl:      tilc_pkg::CTRL_RESET,
                       irq_st:    tilc_pkg::IRQ_RESET,
                       irq_mask:  tilc_pkg::IRQ_RESET,
                       pulse_len: tilc_pkg::PULSE_LEN_RESET,
                       pulse_cnt: 8'h00,
                       tick_cnt:  32'h0000_0000,
                       phase:     8'h00,
                       run_cnt:   4'h0,
                       run_idx:   3'h0,
                       flash:     8'h00,
                       lamps:     5'h00,
                       rdata:     32'h0000_0000,
                       bad_addr:  1'b0};
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // *****************************************************************
    // outputs
    // *****************************************************************
    // zero wait states: the access cycle always completes
    assign pready  = psel & penable;
    assign pslverr = psel & penable & r_reg.bad_addr;
    assign prdata  = r_reg.rdata;

    // open-drain output: only ever pulls low
    assign trig_out_o  = 1'b0;
    assign trig_out_oe = (r_reg.pulse_cnt != 8'h00);

    assign power_status_lamp        = r_reg.lamps[0];
    assign first_channel_port_lamp  = r_reg.lamps[1];
    assign second_channel_port_lamp = r_reg.lamps[2];
    assign err_lamp                 = r_reg.lamps[3];
    assign info_lamp                = r_reg.lamps[4];

    assign logging_active = (r_reg.st == tilc_pkg::ST_LOG);
    assign off_bus        = (r_reg.st == tilc_pkg::ST_STOP);
    assign irq            = |(r_reg.irq_st & r_reg.irq_mask);

endmodule
`default_nettype wire

/* tilc_pkg.sv */
/*
 * constants shared by the trigger input / logger control block: timing,
 * register offsets, field positions, reset values and the state codes.
 * assumes a 125 MHz system clock and a 32-bit apb register bus.
 */
package tilc_pkg;

    // *****************************************************************
    // timing
    // *****************************************************************
    localparam int unsigned CLK_KHZ      = 125000; // pclk rate in kHz
    localparam int unsigned DEB_TIME_MS  = 30;     // debounce hold time
    localparam int unsigned DEB_CYCLES   = DEB_TIME_MS * CLK_KHZ;
    localparam int unsigned TICK_TIME_MS = 10;     // lamp timebase step
    localparam int unsigned TICK_CYCLES  = TICK_TIME_MS * CLK_KHZ;

    // lamp pattern counts, in ticks
    localparam logic [7:0] PHASE_LAST     = 8'h63; // 100 ticks = 1 s
    localparam logic [7:0] ARMED_ON_END   = 8'h5A; // 90 % on
    localparam logic [7:0] SLOW_ON_END    = 8'h32; // 50 % on
    localparam logic [3:0] FLASH_TICKS    = 4'h5;  // short flash length
    localparam logic [3:0] RUN_STEP_TICKS = 4'hA;  // running light step
    localparam int unsigned NUM_LAMPS     = 5;

    // *****************************************************************
    // register map
    // *****************************************************************
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] STATUS_OFS    = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS  = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS  = 8'h0C;
    localparam logic [7:0] PULSE_LEN_OFS = 8'h10;

    // control fields
    localparam int unsigned CTRL_RISING     = 0; // 1: rising edge trigger
    localparam int unsigned CTRL_START_TRIG = 1; // 1: wait for trigger
    localparam int unsigned CTRL_OUT_EN     = 2; // trigger output pulse
    localparam int unsigned CTRL_IFACE      = 3; // interface mode
    localparam int unsigned CTRL_CONFIG     = 4; // config tool attached
    localparam int unsigned CTRL_STOP_TRIG  = 5; // trigger stops logging
    localparam int unsigned CTRL_RESTART    = 6; // write-only, re-arm
    localparam logic [5:0]  CTRL_RESET      = 6'h00;

    // interrupt fields
    localparam int unsigned IRQ_TRIG  = 0;
    localparam int unsigned IRQ_START = 1;
    localparam int unsigned IRQ_STOP  = 2;
    localparam logic [2:0]  IRQ_RESET = 3'h0;

    localparam logic [7:0] PULSE_LEN_RESET = 8'h0A; // 100 ms

    // *****************************************************************
    // logger states
    // *****************************************************************
    typedef enum logic [3:0]
    {
        ST_START = 4'h1,
        ST_ARMED = 4'h2,
        ST_LOG   = 4'h4,
        ST_STOP  = 4'h8
    } tilc_state_e;

endpackage

/* tilc_debounce.sv */
/*
 * trigger pin conditioner: three-flop synchroniser, stability filter and
 * edge pulses. assumes the pin is asynchronous to pclk and idles high.
 */
`timescale 1ns/10ps
`default_nettype none

module tilc_debounce
#(
    parameter int unsigned DEB_CYC = tilc_pkg::DEB_CYCLES
)
(
    input  wire logic pclk,      // system clock
    input  wire logic presetn,   // async reset, active low
    input  wire logic pin_async, // raw trigger pin
    output logic      level,     // filtered level
    output logic      rise,      // one-cycle pulse, filtered 0 -> 1
    output logic      fall       // one-cycle pulse, filtered 1 -> 0
);

    // *****************************************************************
    // state
    // *****************************************************************
    typedef struct packed
    {
        logic [2:0]  sync;  // [0] first stage, read only by [1]
        logic        level; // accepted level
        logic [31:0] cnt;   // cycles the new level has held
        logic        rise;
        logic        fall;
    } tilc_deb_s;

    tilc_deb_s r_reg;       // registered state
    tilc_deb_s r_next;      // next state

    // filter: accept a new level only after it held DEB_CYC cycles
    always_comb
    begin
        r_next = r_reg;
        r_next.sync = {r_reg.sync[1:0], pin_async};
        r_next.rise = 1'b0;
        r_next.fall = 1'b0;
        // second and third stage agree and differ from accepted level
        if ((r_reg.sync[1] == r_reg.sync[2]) &&
            (r_reg.sync[2] != r_reg.level))
        begin
            if (r_reg.cnt == 32'(DEB_CYC - 1))
            begin
                r_next.level = r_reg.sync[2];
                r_next.cnt   = 32'h0000_0000;
                r_next.rise  = r_reg.sync[2];
                r_next.fall  = ~r_reg.sync[2];
            end
            else
            begin
                r_next.cnt = r_reg.cnt + 32'h0000_0001;
            end
        end
        else
        begin
            // a glitch shorter than the hold time restarts the count
            r_next.cnt = 32'h0000_0000;
        end
    end

    // registers; pin is pulled high, so idle level is one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_reg <= '{sync: 3'h7, level: 1'b1, cnt: 32'h0000_0000,
                       rise: 1'b0, fall: 1'b0};
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign level = r_reg.level;
    assign rise  = r_reg.rise;
    assign fall  = r_reg.fall;

endmodule
`default_nettype wire

/* tilc_trig_src.sv */
/* trigger source model: a switch to ground on a pulled-up pin.
   assumes the bench calls hold_low right after a pclk edge. */
`timescale 1ns/10ps
`default_nettype none
module tilc_trig_src
(
    input  wire logic pclk,   // system clock
    output logic      trig_in // pin level seen by the device
);
    initial trig_in = 1'b1; // pull-up holds the idle level high
    // close the switch for cyc cycles, then open it again
    task automatic hold_low(input int cyc);
        @(posedge pclk);
        trig_in <= 1'b0;   // grounded level
        repeat (cyc) @(posedge pclk);
        trig_in <= 1'b1;   // switch opened, pull-up restores the high level
    endtask
endmodule
`default_nettype wire

/* tilc_top_monitor.sv */
/* port checker for tilc_top.
   assumes one pclk domain; bound from the bench. */
`timescale 1ns/10ps
`default_nettype none
module tilc_top_monitor
#(
    parameter int unsigned DEB_CYC = tilc_pkg::DEB_CYCLES // filter hold
)
(
    input wire logic        pclk,                     // clock
    input wire logic        presetn,                  // reset
    input wire logic [7:0]  paddr,                    // apb address
    input wire logic        psel,                     // apb select
    input wire logic        penable,                  // apb access
    input wire logic        pwrite,                   // apb write
    input wire logic [31:0] pwdata,                   // apb data
    input wire logic        pready,                   // apb ready
    input wire logic        pslverr,                  // apb error
    input wire logic        trig_in,                  // trigger pin
    input wire logic [1:0]  chan_traffic,             // traffic
    input wire logic        trig_out_o,               // out level
    input wire logic        trig_out_oe,              // out enable
    input wire logic        power_status_lamp,        // lamp
    input wire logic        first_channel_port_lamp,  // lamp
    input wire logic        second_channel_port_lamp, // lamp
    input wire logic        err_lamp,                 // lamp
    input wire logic        info_lamp,                // lamp
    input wire logic        logging_active,           // logging
    input wire logic        off_bus                   // stopped
);
    logic [1:0]  mode_reg;       // shadow of config/iface bits
    logic        pin_reg = 1'b1; // last pin level
    int unsigned stab_reg = 0;   // cycles the pin has been still
    wire lg = (mode_reg == 2'b00);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // shadow the mode bits from writes to the control word
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            mode_reg <= 2'b00;
        else if (psel && penable && pwrite && paddr == tilc_pkg::CTRL_OFS)
            mode_reg <= pwdata[4:3];
    // pin stillness counter, no reset: the pin lives outside reset
    always_ff @(posedge pclk)
    begin
        pin_reg  <= trig_in;
        stab_reg <= (trig_in != pin_reg) ? 0 : stab_reg + 1;
    end
    pready_zero_a: assert property (psel && penable |-> pready)
        else $error("pready missing in access cycle");
    slverr_access_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access cycle");
    out_pull_low_a: assert property (trig_out_oe |-> !trig_out_o)
        else $error("trigger output not pulling low");
    state_excl_a: assert property (!(logging_active && off_bus))
        else $error("logging and off bus together");
    stop_from_log_a: assert property ($rose(off_bus) |->
        $past(logging_active)) else $error("stop without logging");
    stop_filtered_a: assert property ($rose(off_bus) |->
        stab_reg >= DEB_CYC) else $error("stop on short pulse");
    pulse_filtered_a: assert property ($rose(trig_out_oe) |->
        stab_reg >= DEB_CYC + 2) else $error("pulse on short pin");
    logger_lamps_a: assert property (lg && $past(lg) && $past(presetn)
        |-> {second_channel_port_lamp, first_channel_port_lamp}
        == $past(chan_traffic)) else $error("channel lamps wrong");
    iface_power_a: assert property (mode_reg == 2'b01 &&
        $past(mode_reg) == 2'b01 |-> power_status_lamp)
        else $error("power lamp dark in interface mode");
    config_run_a: assert property (mode_reg[1] && $past(mode_reg[1])
        |-> $onehot({power_status_lamp, first_channel_port_lamp,
        second_channel_port_lamp, err_lamp, info_lamp}))
        else $error("running light not one-hot");
endmodule
`default_nettype wire

/* tilc_top_bench.sv */
/* self-checking bench for tilc_top with short filter and tick.
   assumes tilc_pkg, tilc_top, tilc_trig_src and the monitor. */
`timescale 1ns/10ps
`default_nettype none
module tilc_top_bench;
    localparam int unsigned DEB = 20; // short filter keeps the run brief
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [1:0]  chan_traffic = '0, chan_frame = '0;
    logic        pready, pslverr, er, trig_in, trig_out_o, trig_out_oe;
    logic        power_status_lamp, first_channel_port_lamp, irq;
    logic        second_channel_port_lamp, err_lamp, info_lamp;
    logic        logging_active, off_bus;
    logic [4:0]  lamps_a;
    int          fails = 0, n_checks = 0, n;
    tilc_top #(.DEB_CYC(DEB), .TICK_CYC(4)) tilc_top_inst (.*);
    tilc_trig_src tilc_trig_src_inst (.pclk(pclk), .trig_in(trig_in));
    initial forever #4 pclk = ~pclk;
    // compare one result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; rd and er taken at the ready edge
    task automatic apb(input logic [7:0] a, input logic w, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0; pwrite <= 1'b0;
    endtask
    task automatic st(input logic [3:0] e); // state field of status
        apb(tilc_pkg::STATUS_OFS, 0, 0);
        chk(rd[3:0], e);
    endtask
    task automatic duty(); // power lamp on-count over one 100-tick phase
        repeat (2) @(posedge pclk); // lamp trails the control write by two edges
        n = 0;
        repeat (400) @(posedge pclk) n += (power_status_lamp === 1'b1);
    endtask
    task automatic t_regs();
        apb(tilc_pkg::CTRL_OFS, 0, 0);      chk(rd, 32'h00000000);
        apb(tilc_pkg::PULSE_LEN_OFS, 0, 0); chk(rd, 32'h0000000A);
        st(4'h4);
        apb(tilc_pkg::IRQ_STAT_OFS, 0, 0);  chk(rd, 32'h00000002);
        apb(8'h20, 1, 32'hFFFFFFFF); chk(er, 1);
        apb(8'h20, 0, 0);            chk(rd, 0);
        chk(irq, 0);
        apb(tilc_pkg::IRQ_MASK_OFS, 1, 2); repeat (2) @(posedge pclk);
        chk(irq, 1);
        apb(tilc_pkg::IRQ_STAT_OFS, 1, 2); repeat (2) @(posedge pclk);
        chk(irq, 0);
        apb(tilc_pkg::IRQ_MASK_OFS, 1, 0);
    endtask
    task automatic t_fall(); // falling edge, start on trigger, pulse out
        apb(tilc_pkg::CTRL_OFS, 1, 32'h00000046);
        st(4'h2);
        tilc_trig_src_inst.hold_low(DEB / 2);
        repeat (DEB + 10) @(posedge pclk);
        st(4'h2);
        tilc_trig_src_inst.hold_low(DEB + 20);
        chk(trig_out_oe, 1);
        chk(trig_out_o, 0);
        st(4'h4);
        repeat (60) @(posedge pclk);
        chk(trig_out_oe, 0);
    endtask
    task automatic t_rise(); // rising edge, stop on trigger, lamp duty
        apb(tilc_pkg::CTRL_OFS, 1, 32'h00000063);
        duty(); chk(n, 360);
        fork
            tilc_trig_src_inst.hold_low(3 * DEB);
            begin
                repeat (DEB + 15) @(posedge pclk);
                st(4'h2);
            end
        join
        repeat (DEB + 10) @(posedge pclk);
        st(4'h4);
        tilc_trig_src_inst.hold_low(DEB + 10);
        repeat (DEB + 10) @(posedge pclk);
        st(4'h8);
        chk(off_bus, 1);
        duty(); chk(n, 200);
    endtask
    task automatic t_modes(); // logger, interface and config lamps
        apb(tilc_pkg::CTRL_OFS, 1, 32'h00000040);
        chan_traffic <= 2'b10; repeat (3) @(posedge pclk);
        chk({second_channel_port_lamp, first_channel_port_lamp}, 2);
        apb(tilc_pkg::CTRL_OFS, 1, 32'h00000008);
        chan_frame <= 2'b01; @(posedge pclk) chan_frame <= 2'b00;
        repeat (3) @(posedge pclk);
        chk(power_status_lamp, 1);
        chk(first_channel_port_lamp, 1);
        apb(tilc_pkg::CTRL_OFS, 1, 32'h00000010);
        repeat (3) @(posedge pclk);
        lamps_a = {power_status_lamp, first_channel_port_lamp,
                   second_channel_port_lamp, err_lamp, info_lamp};
        repeat (44) @(posedge pclk);
        chk(lamps_a !== {power_status_lamp, first_channel_port_lamp,
            second_channel_port_lamp, err_lamp, info_lamp}, 1);
    endtask
    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_fall();
        t_rise();
        t_modes();
        report_and_stop();
    end
    initial
    begin
        #200000;
        fails++;
        report_and_stop();
    end
endmodule
bind tilc_top tilc_top_monitor #(.DEB_CYC(DEB_CYC)) mon_inst (.*);
`default_nettype wire
